// file: hw/sce_cfg.svh
// constants for the special-function and control instruction executor
// assumes 16-bit program words and 36-bit accumulators
`ifndef SCE_CFG_SVH
`define SCE_CFG_SVH

`define SCE_WORD_W      16
`define SCE_ACC_W       36
`define SCE_REG32_W     32
`define SCE_CNT_W       16
`define SCE_WS_W        4
`define SCE_WAIT_W      6
`define SCE_PSG_W       10
`define SCE_PAGE_BITS   12
`define SCE_COND_W      5
`define SCE_OP_W        4
`define SCE_EXT_COND_N  12

// instruction word fields
`define SCE_CLASS_HI    15
`define SCE_CLASS_LO    13
`define SCE_OP_HI       12
`define SCE_OP_LO       9
`define SCE_DEST_BIT    8
`define SCE_SRC_BIT     7
`define SCE_MISC_HI     2
`define SCE_MISC_LO     0

// instruction classes
`define SCE_CL_SPEC     3'h0
`define SCE_CL_SPEC_IF  3'h1
`define SCE_CL_SPEC_IFC 3'h2
`define SCE_CL_GOTO     3'h3
`define SCE_CL_CALL     3'h4
`define SCE_CL_MISC     3'h5
`define SCE_CL_IFPRE    3'h6

// misc control selectors
`define SCE_MC_GOTO_PT  3'h0
`define SCE_MC_CALL_PT  3'h1
`define SCE_MC_DEVCALL  3'h2
`define SCE_MC_RETURN   3'h3
`define SCE_MC_IRETURN  3'h4

// condition codes
`define SCE_CC_MI       5'h00
`define SCE_CC_PL       5'h01
`define SCE_CC_EQ       5'h02
`define SCE_CC_NE       5'h03
`define SCE_CC_GT       5'h04
`define SCE_CC_LE       5'h05
`define SCE_CC_LVS      5'h06
`define SCE_CC_LVC      5'h07
`define SCE_CC_MVS      5'h08
`define SCE_CC_MVC      5'h09
`define SCE_CC_C0GE     5'h0A
`define SCE_CC_C0LT     5'h0B
`define SCE_CC_C1GE     5'h0C
`define SCE_CC_C1LT     5'h0D
`define SCE_CC_HEADS    5'h0E
`define SCE_CC_TAILS    5'h0F
`define SCE_CC_TRUE     5'h10
`define SCE_CC_FALSE    5'h11
`define SCE_CC_EXT_BASE 5'h12

// extra cycles beyond the first
`define SCE_CTL_EXTRA   6'h01
`define SCE_DEV_EXTRA   6'h02

`define SCE_RND_BIAS    36'h000008000
`define SCE_RND_MASK    36'hFFFFF0000
`define SCE_PSG_SEED    10'h001

`endif

// file: hw/sce_cond_eval.sv
// combinational condition test with its side-effect requests
// assumes counters and generator bit are held by the caller
`timescale 1ns/1ps
`default_nettype none
`include "sce_cfg.svh"

module sce_cond_eval (
  input  wire logic [`SCE_COND_W-1:0]     cond_code,
  input  wire logic                       test_en,
  input  wire logic [3:0]                 dau_flags,
  input  wire logic [`SCE_EXT_COND_N-1:0] ext_cond,
  input  wire logic                       cnt0_neg,
  input  wire logic                       cnt1_neg,
  input  wire logic                       psg_bit,
  output logic                            cond_true,
  output logic                            inc_cnt0,
  output logic                            inc_cnt1,
  output logic                            step_psg
);

  // dau_flags: [0] negative, [1] zero, [2] logical ovf, [3] math ovf
  logic [4:0] ext_idx;

  always_comb begin
    ext_idx   = cond_code - `SCE_CC_EXT_BASE;
    cond_true = 1'b0;
    case (cond_code)
      `SCE_CC_MI:    cond_true = dau_flags[0];
      `SCE_CC_PL:    cond_true = !dau_flags[0];
      `SCE_CC_EQ:    cond_true = dau_flags[1];
      `SCE_CC_NE:    cond_true = !dau_flags[1];
      `SCE_CC_GT:    cond_true = !dau_flags[0] && !dau_flags[1];
      `SCE_CC_LE:    cond_true = dau_flags[0] || dau_flags[1];
      `SCE_CC_LVS:   cond_true = dau_flags[2];
      `SCE_CC_LVC:   cond_true = !dau_flags[2];
      `SCE_CC_MVS:   cond_true = dau_flags[3];
      `SCE_CC_MVC:   cond_true = !dau_flags[3];
      `SCE_CC_C0GE:  cond_true = !cnt0_neg;
      `SCE_CC_C0LT:  cond_true = cnt0_neg;
      `SCE_CC_C1GE:  cond_true = !cnt1_neg;
      `SCE_CC_C1LT:  cond_true = cnt1_neg;
      `SCE_CC_HEADS: cond_true = psg_bit;
      `SCE_CC_TAILS: cond_true = !psg_bit;
      `SCE_CC_TRUE:  cond_true = 1'b1;
      `SCE_CC_FALSE: cond_true = 1'b0;
      default: begin
        if (ext_idx < 5'(`SCE_EXT_COND_N)) begin
          cond_true = ext_cond[ext_idx[3:0]];
        end
      end
    endcase
    inc_cnt0 = test_en && (cond_code == `SCE_CC_C0GE ||
                           cond_code == `SCE_CC_C0LT);
    inc_cnt1 = test_en && (cond_code == `SCE_CC_C1GE ||
                           cond_code == `SCE_CC_C1LT);
    step_psg = test_en && (cond_code == `SCE_CC_HEADS ||
                           cond_code == `SCE_CC_TAILS);
  end

endmodule // sce_cond_eval
`default_nettype wire

// file: hw/sce_exec.sv
// special-function and control instruction executor of a dsp core
// assumes program memory offers one word per cycle at prog_addr while
// prog_req is high, flagged by prog_valid and prog_from_cache
`timescale 1ns/1ps
`default_nettype none
`include "sce_cfg.svh"

module sce_exec #(
  parameter logic [`SCE_WORD_W-1:0] DEV_CALL_VECTOR = 16'h0000,
  parameter logic [`SCE_PSG_W-1:0]  PSG_SEED        = `SCE_PSG_SEED
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       prog_valid,
  input  wire logic [`SCE_WORD_W-1:0]     prog_word,
  input  wire logic                       prog_from_cache,
  input  wire logic                       pc_ext,
  input  wire logic                       pt_ext,
  input  wire logic                       pr_ext,
  input  wire logic [`SCE_WS_W-1:0]       wait_states,
  input  wire logic [`SCE_REG32_W-1:0]    y_reg,
  input  wire logic [`SCE_REG32_W-1:0]    p_reg,
  input  wire logic [`SCE_WORD_W-1:0]     pointer_table_reg,
  input  wire logic [3:0]                 dau_flags,
  input  wire logic [`SCE_EXT_COND_N-1:0] ext_cond,
  output logic      [`SCE_WORD_W-1:0]     prog_addr,
  output logic                            prog_req,
  output logic                            cache_bypass,
  output logic      [`SCE_ACC_W-1:0]      acc0,
  output logic      [`SCE_ACC_W-1:0]      acc1,
  output logic      [`SCE_WORD_W-1:0]     return_address_reg,
  output logic      [`SCE_WORD_W-1:0]     interrupt_return_reg,
  output logic      [`SCE_CNT_W-1:0]      event_counter_zero,
  output logic      [`SCE_CNT_W-1:0]      event_counter_one,
  output logic      [`SCE_CNT_W-1:0]      event_count_copy,
  output logic                            psg_bit
);

  generate
    if (PSG_SEED == 10'h000) begin : g_bad_seed
      $error("sce_exec: PSG_SEED must be nonzero");
    end
  endgenerate

  sce_pkg::sce_top_state_type r;
  sce_pkg::sce_top_state_type next_r;

  logic [2:0]               cls;
  logic [2:0]               misc;
  logic                     is_spec;
  logic                     is_ctl;
  logic                     ctl_ok_cond;
  logic [`SCE_ACC_W-1:0]    alu_src;
  logic [`SCE_ACC_W-1:0]    alu_res;
  logic [`SCE_COND_W-1:0]   cond_code;
  logic                     test_en;
  logic                     cond_true;
  logic                     inc_cnt0;
  logic                     inc_cnt1;
  logic                     step_psg;
  logic [`SCE_WAIT_W-1:0]   ws_ext;
  logic [`SCE_WORD_W-1:0]   pc_next_word;
  logic [`SCE_WORD_W-1:0]   pc_advanced;

  assign cls          = prog_word[`SCE_CLASS_HI:`SCE_CLASS_LO];
  assign misc         = prog_word[`SCE_MISC_HI:`SCE_MISC_LO];
  assign is_spec      = cls == `SCE_CL_SPEC || cls == `SCE_CL_SPEC_IF ||
                        cls == `SCE_CL_SPEC_IFC;
  assign is_ctl       = cls == `SCE_CL_GOTO || cls == `SCE_CL_CALL ||
                        cls == `SCE_CL_MISC;
  assign ctl_ok_cond  = is_ctl && !(cls == `SCE_CL_MISC &&
                        (misc == `SCE_MC_DEVCALL ||
                         misc == `SCE_MC_IRETURN));
  assign ws_ext       = `SCE_WAIT_W'(wait_states);
  assign pc_next_word = r.pc + 16'h0001;
  assign pc_advanced  = r.pc + 16'h0002;

  assign alu_src   = prog_word[`SCE_SRC_BIT] ? r.acc1 : r.acc0;
  assign cond_code = (r.st == sce_pkg::ST_CTL2) ? r.pend_cond :
                     prog_word[`SCE_COND_W-1:0];
  assign test_en   = ce && prog_valid &&
                     ((r.st == sce_pkg::ST_EXEC && is_spec &&
                       cls != `SCE_CL_SPEC) ||
                      (r.st == sce_pkg::ST_CTL2 && ctl_ok_cond &&
                       !prog_from_cache));

  sce_spec_alu u_alu (
    .op     (prog_word[`SCE_OP_HI:`SCE_OP_LO]),
    .src    (alu_src),
    .y_val  (y_reg),
    .p_val  (p_reg),
    .result (alu_res)
  );

  sce_cond_eval u_cond (
    .cond_code (cond_code),
    .test_en   (test_en),
    .dau_flags (dau_flags),
    .ext_cond  (ext_cond),
    .cnt0_neg  (r.cnt0[`SCE_CNT_W-1]),
    .cnt1_neg  (r.cnt1[`SCE_CNT_W-1]),
    .psg_bit   (r.psg[0]),
    .cond_true (cond_true),
    .inc_cnt0  (inc_cnt0),
    .inc_cnt1  (inc_cnt1),
    .step_psg  (step_psg)
  );

  // executes one control word at r.pc; base is the cycle count minus one
  function automatic sce_pkg::sce_top_state_type do_ctl(
    input sce_pkg::sce_top_state_type s,
    input logic [`SCE_WAIT_W-1:0]     base
  );
    sce_pkg::sce_top_state_type t;
    logic [`SCE_WAIT_W-1:0]     extra;
    t     = s;
    extra = base + (pc_ext ? ws_ext : 6'h00);
    unique case (cls)
      `SCE_CL_GOTO, `SCE_CL_CALL: begin
        t.pc = {pc_advanced[`SCE_WORD_W-1:`SCE_PAGE_BITS],
                prog_word[`SCE_PAGE_BITS-1:0]};
        if (cls == `SCE_CL_CALL) begin
          t.ret_addr = pc_next_word;
        end
      end
      default: begin
        unique case (misc)
          `SCE_MC_GOTO_PT, `SCE_MC_CALL_PT: begin
            t.pc = pointer_table_reg;
            if (pt_ext) begin
              extra = extra + ws_ext;
            end
            if (misc == `SCE_MC_CALL_PT) begin
              t.ret_addr = pc_next_word;
            end
          end
          `SCE_MC_DEVCALL: begin
            t.pc      = DEV_CALL_VECTOR;
            t.int_ret = pc_next_word;
            extra     = extra + `SCE_DEV_EXTRA - `SCE_CTL_EXTRA;
          end
          `SCE_MC_RETURN: begin
            t.pc = s.ret_addr;
            if (pr_ext) begin
              extra = extra + ws_ext;
            end
          end
          `SCE_MC_IRETURN: t.pc = s.int_ret;
          default:         t.pc = pc_next_word;
        endcase
      end
    endcase
    t.wait_cnt = extra;
    t.st       = sce_pkg::ST_WAIT;
    return t;
  endfunction

  always_comb begin
    next_r        = r;
    next_r.bypass = 1'b0;
    if (inc_cnt0) begin
      next_r.cnt0 = r.cnt0 + 16'h0001;
    end
    if (step_psg) begin
      next_r.psg = {r.psg[0] ^ r.psg[3], r.psg[9:1]};
    end
    unique case (r.st)
      sce_pkg::ST_EXEC: begin
        if (prog_valid) begin
          if (is_spec) begin
            // special words may run from cache
            next_r.pc = pc_next_word;
            if ((cls == `SCE_CL_SPEC) || cond_true) begin
              if (prog_word[`SCE_DEST_BIT]) begin
                next_r.acc1 = alu_res;
              end else begin
                next_r.acc0 = alu_res;
              end
            end
            if (cls == `SCE_CL_SPEC_IFC) begin
              next_r.cnt1 = r.cnt1 + 16'h0001 +
                            {15'h0000, inc_cnt1};
              if (cond_true) begin
                next_r.cnt2 = next_r.cnt1;
              end
            end else if (inc_cnt1) begin
              next_r.cnt1 = r.cnt1 + 16'h0001;
            end
            if (pc_ext && wait_states != 4'h0) begin
              next_r.wait_cnt = ws_ext;
              next_r.st       = sce_pkg::ST_WAIT;
            end
          end else if ((is_ctl || cls == `SCE_CL_IFPRE) &&
                       prog_from_cache) begin
            next_r.bypass = 1'b1;
          end else if (is_ctl) begin
            next_r = do_ctl(next_r, `SCE_CTL_EXTRA);
          end else if (cls == `SCE_CL_IFPRE) begin
            next_r.pend_cond = prog_word[`SCE_COND_W-1:0];
            next_r.pc        = pc_next_word;
            next_r.st        = sce_pkg::ST_CTL2;
          end else begin
            next_r.pc = pc_next_word;
          end
        end
      end
      sce_pkg::ST_CTL2: begin
        if (prog_valid) begin
          if (prog_from_cache) begin
            next_r.bypass = 1'b1;
          end else begin
            if (inc_cnt1) begin
              next_r.cnt1 = r.cnt1 + 16'h0001;
            end
            if (ctl_ok_cond && cond_true) begin
              next_r = do_ctl(next_r, `SCE_CTL_EXTRA);
            end else begin
              next_r.pc       = pc_next_word;
              next_r.wait_cnt = `SCE_CTL_EXTRA +
                                (pc_ext ? ws_ext : 6'h00);
              next_r.st       = sce_pkg::ST_WAIT;
            end
          end
        end
      end
      sce_pkg::ST_WAIT: begin
        next_r.wait_cnt = r.wait_cnt - 6'h01;
        if (r.wait_cnt <= 6'h01) begin
          next_r.wait_cnt = 6'h00;
          next_r.st       = sce_pkg::ST_EXEC;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r          <= '0;
      r.st       <= sce_pkg::ST_EXEC;
      r.psg      <= PSG_SEED;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ports below are register copies; prog_req is registered from the next state not being ST_WAIT
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prog_addr            <= 16'h0000;
      prog_req             <= 1'b0;
      cache_bypass         <= 1'b0;
      acc0                 <= 36'h000000000;
      acc1                 <= 36'h000000000;
      return_address_reg   <= 16'h0000;
      interrupt_return_reg <= 16'h0000;
      event_counter_zero   <= 16'h0000;
      event_counter_one    <= 16'h0000;
      event_count_copy     <= 16'h0000;
      psg_bit              <= 1'b0;
    end else if (ce) begin
      prog_addr            <= next_r.pc;
      prog_req             <= next_r.st != sce_pkg::ST_WAIT;
      cache_bypass         <= next_r.bypass;
      acc0                 <= next_r.acc0;
      acc1                 <= next_r.acc1;
      return_address_reg   <= next_r.ret_addr;
      interrupt_return_reg <= next_r.int_ret;
      event_counter_zero   <= next_r.cnt0;
      event_counter_one    <= next_r.cnt1;
      event_count_copy     <= next_r.cnt2;
      psg_bit              <= next_r.psg[0];
    end
  end

endmodule // sce_exec
`default_nettype wire

// file: hw/sce_pkg.sv
// types for the special-function and control instruction executor
// assumes sce_cfg.svh is on the include path
`include "sce_cfg.svh"

package sce_pkg;

  typedef enum logic [3:0] {
    OP_SHR1  = 4'h0,
    OP_SHR4  = 4'h1,
    OP_SHR8  = 4'h2,
    OP_SHR16 = 4'h3,
    OP_COPY  = 4'h4,
    OP_NEG   = 4'h5,
    OP_NOT   = 4'h6,
    OP_RND   = 4'h7,
    OP_INCH  = 4'h8,
    OP_INC   = 4'h9,
    OP_LDY   = 4'hA,
    OP_LDP   = 4'hB,
    OP_SHL1  = 4'hC,
    OP_SHL4  = 4'hD,
    OP_SHL8  = 4'hE,
    OP_SHL16 = 4'hF
  } sce_op_type;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_CTL2 = 3'b010,
    ST_WAIT = 3'b100
  } sce_state_type;

  typedef struct packed {
    sce_state_type                st;
    logic [`SCE_WORD_W-1:0]       pc;
    logic [`SCE_WAIT_W-1:0]       wait_cnt;
    logic [`SCE_ACC_W-1:0]        acc0;
    logic [`SCE_ACC_W-1:0]        acc1;
    logic [`SCE_WORD_W-1:0]       ret_addr;
    logic [`SCE_WORD_W-1:0]       int_ret;
    logic [`SCE_CNT_W-1:0]        cnt0;
    logic [`SCE_CNT_W-1:0]        cnt1;
    logic [`SCE_CNT_W-1:0]        cnt2;
    logic [`SCE_PSG_W-1:0]        psg;
    logic [`SCE_COND_W-1:0]       pend_cond;
    logic                         bypass;
  } sce_top_state_type;

endpackage

// file: hw/sce_spec_alu.sv
// combinational special-function datapath for one accumulator result
// assumes operands are already selected by the caller
`timescale 1ns/1ps
`default_nettype none
`include "sce_cfg.svh"

module sce_spec_alu (
  input  wire logic [`SCE_OP_W-1:0]    op,
  input  wire logic [`SCE_ACC_W-1:0]   src,
  input  wire logic [`SCE_REG32_W-1:0] y_val,
  input  wire logic [`SCE_REG32_W-1:0] p_val,
  output logic      [`SCE_ACC_W-1:0]   result
);

  logic [`SCE_REG32_W-1:0] low_shl;
  logic [15:0]             zero_half;

  always_comb begin
    zero_half = 16'h0000;
    low_shl   = src[31:0];
    result    = src;
    unique case (sce_pkg::sce_op_type'(op))
      sce_pkg::OP_SHR1:  result = $signed(src) >>> 1;
      sce_pkg::OP_SHR4:  result = $signed(src) >>> 4;
      sce_pkg::OP_SHR8:  result = $signed(src) >>> 8;
      sce_pkg::OP_SHR16: result = $signed(src) >>> 16;
      sce_pkg::OP_COPY:  result = src;
      sce_pkg::OP_NEG:   result = -src;
      sce_pkg::OP_NOT:   result = ~src;
      sce_pkg::OP_RND:
        result = (src + `SCE_RND_BIAS) & `SCE_RND_MASK;
      sce_pkg::OP_INCH:
        result = {src[35:16] + 20'h00001, zero_half};
      sce_pkg::OP_INC:   result = src + 36'h000000001;
      sce_pkg::OP_LDY:   result = {{4{y_val[31]}}, y_val};
      sce_pkg::OP_LDP:   result = {{4{p_val[31]}}, p_val};
      default: begin
        // left shifts: low 32 bits only, top nibble copies bit 31
        unique case (op[1:0])
          2'h0: low_shl = src[31:0] << 1;
          2'h1: low_shl = src[31:0] << 4;
          2'h2: low_shl = src[31:0] << 8;
          2'h3: low_shl = src[31:0] << 16;
        endcase
        result = {{4{low_shl[31]}}, low_shl};
      end
    endcase
  end

endmodule // sce_spec_alu
`default_nettype wire

// file: tb/sce_exec_properties.sv
// port assertions for the instruction executor
// assumes a bind onto sce_exec and its single clock
`timescale 1ns/1ps
`default_nettype none
module sce_exec_properties (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        prog_valid,
  input wire logic [15:0] prog_word,
  input wire logic        prog_from_cache,
  input wire logic        pc_ext,
  input wire logic [3:0]  wait_states,
  input wire logic [15:0] prog_addr,
  input wire logic        prog_req,
  input wire logic        cache_bypass,
  input wire logic [35:0] acc0,
  input wire logic [35:0] acc1,
  input wire logic [15:0] return_address_reg,
  input wire logic [15:0] event_counter_zero,
  input wire logic [15:0] event_counter_one,
  input wire logic [15:0] event_count_copy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic             pref;
  wire logic        take = ce && prog_req && prog_valid;
  wire logic [2:0]  cls  = prog_word[15:13];
  wire logic [15:0] pa2  = prog_addr + 16'h0002;
  wire logic        sp   = take && cls <= 3'h2 && !pref;
  // remembers an accepted uncached prefix until the next accepted uncached word
  always_ff @(posedge sys_clk) begin
    if (rst)
      pref <= 1'b0;
    else if (take && !prog_from_cache)
      pref <= cls == 3'h6;
  end
  sequence s_ctl;
    take && !prog_from_cache && !pc_ext;
  endsequence
  sequence s_end;
    !prog_req ##1 prog_req;
  endsequence
  a_goto_page: assert property (
    s_ctl ##0 (cls == 3'h3 && !pref)
    |=> prog_addr == {$past(pa2[15:12]), $past(prog_word[11:0])})
    else $error("direct jump target off page");
  a_ctl_two: assert property (
    s_ctl ##0 (cls inside {3'h3, 3'h4} && !pref) |=> s_end)
    else $error("unconditional control not two cycles");
  a_cond_three: assert property (
    s_ctl ##0 (cls == 3'h6) ##1 (take && cls == 3'h3) |=> s_end)
    else $error("conditional control not three cycles");
  a_pref_next: assert property (
    s_ctl ##0 (cls == 3'h6) |=> prog_req)
    else $error("second control word not awaited");
  a_call_save: assert property (
    s_ctl ##0 (cls == 3'h4 && !pref)
    |=> return_address_reg == $past(prog_addr) + 16'h0001)
    else $error("call saved wrong return address");
  a_cache_refuse: assert property (
    take && prog_from_cache && cls inside {[3'h3:3'h6]}
    |=> cache_bypass && $stable(prog_addr))
    else $error("cached control word not refused");
  a_spec_step: assert property (
    sp && !pc_ext |=> prog_req && prog_addr == $past(prog_addr) + 16'h0001)
    else $error("special function not one cycle");
  a_wait_hold: assert property (
    sp && pc_ext && wait_states != 4'h0 |=> !prog_req ##[1:15] prog_req)
    else $error("wait states not inserted");
  a_false_keep: assert property (
    sp && cls == 3'h1 && prog_word[4:0] == 5'h11
    |=> $stable(acc0) && $stable(acc1))
    else $error("false condition changed an accumulator");
  a_ifc_count: assert property (
    sp && cls == 3'h2 && prog_word[4:1] != 4'h6
    |=> event_counter_one == $past(event_counter_one) + 16'h0001)
    else $error("event counter one not advanced");
  a_ifc_copy: assert property (
    sp && cls == 3'h2 && prog_word[4:0] == 5'h10
    |=> event_count_copy == event_counter_one)
    else $error("event count not copied");
  a_c0_bump: assert property (
    sp && cls == 3'h1 && prog_word[4:1] == 4'h5
    |=> event_counter_zero == $past(event_counter_zero) + 16'h0001)
    else $error("counter zero not advanced by its test");
endmodule // sce_exec_properties
bind sce_exec sce_exec_properties u_props (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .prog_valid(prog_valid),
  .prog_word(prog_word), .prog_from_cache(prog_from_cache),
  .pc_ext(pc_ext), .wait_states(wait_states), .prog_addr(prog_addr),
  .prog_req(prog_req), .cache_bypass(cache_bypass), .acc0(acc0),
  .acc1(acc1), .return_address_reg(return_address_reg),
  .event_counter_zero(event_counter_zero),
  .event_counter_one(event_counter_one),
  .event_count_copy(event_count_copy));
`default_nettype wire

// file: tb/sce_prog_mem.sv
// program memory model feeding the executor one word per cycle, every other cycle in slow mode
// assumes words are offered at the falling edge; unset words are nops
`timescale 1ns/1ps
`default_nettype none
module sce_prog_mem (
  input  wire logic        sys_clk,
  input  wire logic        prog_req,
  input  wire logic [15:0] prog_addr,
  input  wire logic        cache_bypass,
  input  wire logic        slow,
  input  wire logic        cache_on,
  output logic             prog_valid,
  output logic [15:0]      prog_word,
  output logic             prog_from_cache
);
  logic [15:0] mem [logic [15:0]];
  logic        skip = 1'b0;
  initial begin
    prog_valid = 1'b0;
    prog_word = 16'h0000;
    prog_from_cache = 1'b0;
  end
  task automatic load(input logic [15:0] a, input logic [15:0] d);
    mem[a] = d;
  endtask
  task automatic clear();
    mem.delete();
  endtask
  // slow mode answers every other cycle; idle bus shows inverted junk
  always @(negedge sys_clk) begin
    skip <= slow && !skip;
    if (prog_req && !(slow && !skip)) begin
      prog_valid <= 1'b1;
      prog_word <= mem.exists(prog_addr) ? mem[prog_addr] : 16'hE000;
      prog_from_cache <= cache_on && !cache_bypass;
    end else begin
      prog_valid <= 1'b0;
      prog_word <= ~prog_word;
    end
  end
endmodule // sce_prog_mem
`default_nettype wire

// file: tb/tb_sce_exec.sv
// self-checking bench for the instruction executor
// assumes sce_prog_mem as program memory and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_sce_exec;
  logic        sys_clk, rst, pc_ext, slow, cache_on;
  logic        prog_valid, prog_from_cache, prog_req, cache_bypass, psg_bit;
  logic [3:0]  wait_states, dau_flags;
  logic [11:0] ext_cond;
  logic [15:0] prog_word, prog_addr, ra, ira, c0, c1, c2;
  logic [31:0] y_reg, p_reg;
  logic [35:0] acc0, acc1;
  int          err_count, checks, cyc, byp;
  sce_prog_mem u_mem (.sys_clk(sys_clk), .prog_req(prog_req),
    .prog_addr(prog_addr), .cache_bypass(cache_bypass), .slow(slow),
    .cache_on(cache_on), .prog_valid(prog_valid), .prog_word(prog_word),
    .prog_from_cache(prog_from_cache));
  sce_exec u_dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
    .prog_valid(prog_valid), .prog_word(prog_word),
    .prog_from_cache(prog_from_cache), .pc_ext(pc_ext), .pt_ext(1'b0),
    .pr_ext(1'b0), .wait_states(wait_states), .y_reg(y_reg),
    .p_reg(p_reg), .pointer_table_reg(16'h0000), .dau_flags(dau_flags),
    .ext_cond(ext_cond), .prog_addr(prog_addr), .prog_req(prog_req),
    .cache_bypass(cache_bypass), .acc0(acc0), .acc1(acc1),
    .return_address_reg(ra), .interrupt_return_reg(ira),
    .event_counter_zero(c0), .event_counter_one(c1),
    .event_count_copy(c2), .psg_bit(psg_bit));
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    cyc++;
    if (cache_bypass === 1'b1)
      byp++;
    if (cyc == 10000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] w(input logic [2:0] c, input logic [3:0] o,
      input logic d, input logic s, input logic [4:0] k);
    return {c, o, d, s, 2'b00, k};
  endfunction
  function automatic logic [35:0] model(input logic [3:0] op,
      input logic [35:0] s);
    logic [4:0]  sh;
    logic [31:0] t;
    sh = (op[1:0] == 2'h0) ? 5'h01 : 5'h04 << (op[1:0] - 2'h1);
    t = s[31:0] << sh;
    case (op)
      4'h0, 4'h1, 4'h2, 4'h3: model = $signed(s) >>> sh;
      4'h4: model = s;
      4'h5: model = -s;
      4'h6: model = ~s;
      4'h7: model = (s + 36'h000008000) & 36'hFFFFF0000;
      4'h8: model = {s[35:16] + 20'h00001, 16'h0000};
      4'h9: model = s + 36'h000000001;
      4'hA: model = {{4{y_reg[31]}}, y_reg};
      4'hB: model = {{4{p_reg[31]}}, p_reg};
      default: model = {{4{t[31]}}, t};
    endcase
  endfunction
  // no program here uses the debug call
  task automatic prog(input logic [15:0] q[$]);
    u_mem.clear();
    foreach (q[i]) u_mem.load(16'(i), q[i]);
  endtask
  // resets, then counts cycles until the halt word is first fetched
  task automatic run(input logic [15:0] h, output int n);
    n = 0;
    rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    while (!(prog_addr === h && prog_req === 1'b1) && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    chk(36'(n < 200), 36'h1);
  endtask
  task automatic t_ops();
    logic [35:0] src, r;
    logic        b;
    int          n;
    for (int op = 0; op < 16; op++) begin
      b = op[0];
      src = b ? {{4{y_reg[31]}}, y_reg} : {{4{p_reg[31]}}, p_reg};
      r = model(4'(op), src);
      prog({w(3'h0, b ? 4'hA : 4'hB, ~b, 1'b0, 5'h00),
            w(3'h0, 4'(op), b, ~b, 5'h00), 16'h6002});
      run(16'h0002, n);
      chk(b ? acc1 : acc0, r);
      chk(b ? acc0 : acc1, src);
      chk(36'(n), 36'h2);
    end
    $display("special function test done");
  endtask
  task automatic t_cond();
    logic [35:0] s;
    int          n;
    s = {{4{y_reg[31]}}, y_reg};
    slow = 1'b1;
    dau_flags = 4'h1;
    ext_cond = 12'h001;
    prog({w(3'h0, 4'hA, 0, 0, 5'h00), w(3'h1, 4'h4, 1, 0, 5'h00),
          w(3'h1, 4'h5, 0, 0, 5'h01), w(3'h2, 4'h9, 1, 1, 5'h11),
          w(3'h2, 4'h9, 1, 1, 5'h10), w(3'h1, 4'h4, 0, 0, 5'h0A),
          w(3'h2, 4'h4, 0, 0, 5'h0D), w(3'h1, 4'h6, 0, 0, 5'h12),
          w(3'h1, 4'h5, 0, 0, 5'h0F), 16'h6009});
    run(16'h0009, n);
    chk(acc0, ~s);
    chk(acc1, s + 36'h000000001);
    chk(36'(c0), 36'h1);
    chk(36'(c1), 36'h4);
    chk(36'(c2), 36'h2);
    chk(36'(psg_bit), 36'h0);
    slow = 1'b0;
    $display("conditional test done");
  endtask
  task automatic t_ctl();
    int n;
    dau_flags = 4'h0;
    prog({16'h8010, 16'h6FFE});
    u_mem.load(16'h0010, 16'hC002);
    u_mem.load(16'h0011, 16'h6020);
    u_mem.load(16'h0012, 16'hC010);
    u_mem.load(16'h0013, 16'hA003);
    u_mem.load(16'h0FFE, 16'h6040);
    u_mem.load(16'h1040, 16'h6040);
    run(16'h1040, n);
    chk(36'(n), 36'hC);
    chk(36'(ra), 36'h1);
    $display("control test done");
  endtask
  task automatic t_cache();
    int n;
    cache_on = 1'b1;
    byp = 0;
    prog({w(3'h0, 4'hA, 0, 0, 5'h00), 16'h6003, w(3'h0, 4'h6, 0, 0, 5'h00),
          16'h6003});
    run(16'h0003, n);
    chk(acc0, {{4{y_reg[31]}}, y_reg});
    chk(36'(byp != 0), 36'h1);
    cache_on = 1'b0;
    $display("cache test done");
  endtask
  task automatic t_wait();
    int n;
    pc_ext = 1'b1;
    wait_states = 4'h3;
    prog({w(3'h0, 4'hA, 0, 0, 5'h00), w(3'h0, 4'h4, 1, 0, 5'h00), 16'h6002});
    run(16'h0002, n);
    chk(36'(n), 36'h8);
    chk(acc1, {{4{y_reg[31]}}, y_reg});
    pc_ext = 1'b0;
    $display("wait state test done");
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    pc_ext = 1'b0;
    slow = 1'b0;
    cache_on = 1'b0;
    wait_states = 4'h0;
    dau_flags = 4'h0;
    ext_cond = 12'h000;
    y_reg = 32'h87654321;
    p_reg = 32'h12345678;
    t_ops();
    t_cond();
    t_ctl();
    t_cache();
    t_wait();
    print_verdict();
  end
endmodule // tb_sce_exec
`default_nettype wire
